// ==== rtl/i2c_port_defs.svh ====
// Constants for the two-wire slave port and its master end
`ifndef I2C_PORT_DEFS_SVH
`define I2C_PORT_DEFS_SVH

`define CLK_PERIOD_NS        25
`define STRETCH_INTERVAL_US  60
`define STRETCH_CYCLES       ((`STRETCH_INTERVAL_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BUS_FREE_INTERVAL_US 10
`define BUS_FREE_CYCLES      ((`BUS_FREE_INTERVAL_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DATA_SETTLE_NS       250
`define DATA_SETTLE_CYCLES   ((`DATA_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ADDR_UPPER           4'hC
`define PTR_BITS             6
`define PTR_RESET            6'h00
`define SCL_HALF_CYCLES      100
`define SCL_HALF_W           8

`endif

// ==== rtl/i2c_port_pkg.sv ====
// Types shared by both ends of the two-wire link
package i2c_port_pkg;
   typedef enum logic [2:0] {
      S_IDLE  = 3'b000,
      S_ADDR  = 3'b001,
      S_AACK  = 3'b010,
      S_WRX   = 3'b011,
      S_WACK  = 3'b100,
      S_RTX   = 3'b101,
      S_RACK  = 3'b110,
      S_SKIP  = 3'b111
   } slave_state_t;

   typedef enum logic [3:0] {
      M_IDLE  = 4'b0000,
      M_START = 4'b0001,
      M_BIT   = 4'b0010,
      M_ACK   = 4'b0011,
      M_STOP  = 4'b0100,
      M_FREE  = 4'b0101,
      M_RSTRT = 4'b0110
   } master_state_t;
endpackage

// ==== rtl/i2c_link_if.sv ====
// Two-wire link between the master and the slave port
`timescale 1ns/1ps
`default_nettype none
interface i2c_link_if;
   logic scl_m_o;
   logic scl_m_oe;
   logic sda_m_o;
   logic sda_m_oe;
   logic scl_s_o;
   logic scl_s_oe;
   logic sda_s_o;
   logic sda_s_oe;
   wire  scl;
   wire  sda;

   // Open drain: any enabled driver pulls low, pull-up otherwise
   assign scl = ~((scl_m_oe & ~scl_m_o) | (scl_s_oe & ~scl_s_o));
   assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));

   modport master (output scl_m_o, scl_m_oe, sda_m_o, sda_m_oe, input scl, sda);
   modport slave  (output scl_s_o, scl_s_oe, sda_s_o, sda_s_oe, input scl, sda);
endinterface
`default_nettype wire

// ==== rtl/i2c_slave_port.sv ====
// Slave end: address match, pointer, byte shifting and clock stretch
`include "i2c_port_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_port
   import i2c_port_pkg::*;
#(
   parameter int STRETCH_CYCLES = `STRETCH_CYCLES
) (
   // Clock and reset
   input  wire logic       clk_sys_i,
   input  wire logic       sys_rst_i,
   // Link
   i2c_link_if.slave       link,
   // Address select level, already quantised to one of eight
   input  wire logic [2:0] addr_sel_i,
   // Register file side
   output logic [5:0]      reg_ptr_o,
   output logic [7:0]      wr_data_o,
   output logic            wr_stb_o,
   input  wire logic [7:0] rd_data_i,
   output logic            busy_o
);
   slave_state_t state_q, state_d;
   logic [1:0]  scl_sync_q, sda_sync_q;
   logic        scl_q, sda_q;
   logic [2:0]  bit_cnt_q;
   logic [7:0]  shift_q;
   logic [7:0]  tx_q;
   logic [5:0]  ptr_q;
   logic        ptr_loaded_q;
   logic [2:0]  addr_meta_q;
   logic [2:0]  addr_q;
   logic        sda_drv_q, scl_drv_q;
   logic [15:0] str_cnt_q;
   logic        wr_stb_q;
   logic        busy_q;

   // Two flops tame the pins; the third stage only feeds the edge detectors
   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         scl_sync_q <= 2'h3;
         sda_sync_q <= 2'h3;
         scl_q      <= 1'b1;
         sda_q      <= 1'b1;
      end else begin
         scl_sync_q <= {scl_sync_q[0], link.scl};
         sda_sync_q <= {sda_sync_q[0], link.sda};
         scl_q      <= scl_sync_q[1];
         sda_q      <= sda_sync_q[1];
      end
   end

   wire scl_s     = scl_sync_q[1];
   wire sda_s     = sda_sync_q[1];
   wire scl_rise  = scl_s & ~scl_q;
   wire scl_fall  = ~scl_s & scl_q;
   wire start_det = scl_s & scl_q & sda_q & ~sda_s;
   wire stop_det  = scl_s & scl_q & ~sda_q & sda_s;
   wire last_bit  = (bit_cnt_q == 3'h7);
   // Address: fixed 1100 prefix plus select level; bit 0 of byte is direction
   wire [6:0] own_addr = {`ADDR_UPPER, addr_q};
   // Byte completed by the current rising edge (sampled bit appended)
   wire [7:0] rx_byte = {shift_q[6:0], sda_s};
   wire addr_hit  = (rx_byte[7:1] == own_addr);
   wire rnw       = shift_q[0];

   // Select level is a pin: two flops before the compare, never under reset
   always_ff @(posedge clk_sys_i) begin
      addr_meta_q <= addr_sel_i;
      addr_q      <= addr_meta_q;
   end

   // Next state: start and stop override everything, mid-byte included
   always_comb begin
      state_d = state_q;
      if (stop_det) begin
         state_d = S_IDLE;
      end else if (start_det) begin
         state_d = S_ADDR;
      end
   end

   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_q      <= S_IDLE;
         bit_cnt_q    <= 3'h0;
         shift_q      <= 8'h00;
         tx_q         <= 8'h00;
         ptr_q        <= `PTR_RESET;
         ptr_loaded_q <= 1'b0;
         sda_drv_q    <= 1'b0;
         scl_drv_q    <= 1'b0;
         str_cnt_q    <= 16'h0000;
         wr_stb_q     <= 1'b0;
         busy_q       <= 1'b0;
      end else begin
         wr_stb_q <= 1'b0;
         // Bus conditions outrank the byte machine; every drive drops at once
         if (stop_det) begin
            state_q   <= state_d;
            sda_drv_q <= 1'b0;
            scl_drv_q <= 1'b0;
            busy_q    <= 1'b0;
         end else if (start_det) begin
            state_q      <= state_d;
            bit_cnt_q    <= 3'h0;
            sda_drv_q    <= 1'b0;
            scl_drv_q    <= 1'b0;
            ptr_loaded_q <= 1'b0;
            busy_q       <= 1'b1;
         end else begin
            // Stretch: hold SCL low, then fetch fresh data and release
            // Fetching at the end gives the register file time after a pointer move
            if (scl_drv_q) begin
               if (str_cnt_q == 16'h0000) begin
                  scl_drv_q <= 1'b0;
                  tx_q      <= rd_data_i;
                  sda_drv_q <= ~rd_data_i[7];
               end else begin
                  str_cnt_q <= str_cnt_q - 16'h0001;
               end
            end
            case (state_q)
               S_ADDR, S_WRX: if (scl_rise) begin
                  shift_q   <= rx_byte;
                  bit_cnt_q <= bit_cnt_q + 3'h1;
                  if (last_bit) begin
                     if (state_q == S_ADDR) begin
                        state_q <= addr_hit ? S_AACK : S_SKIP;
                     end else begin
                        state_q <= S_WACK;
                        if (!ptr_loaded_q) begin
                           ptr_q        <= rx_byte[5:0];
                           ptr_loaded_q <= 1'b1;
                        end else begin
                           wr_stb_q <= 1'b1;
                        end
                     end
                  end
               end
               S_AACK, S_WACK: begin
                  // Ack driven low across the ninth clock, released after it
                  if (scl_fall && !sda_drv_q) begin
                     sda_drv_q <= 1'b1;
                  end else if (scl_fall && sda_drv_q) begin
                     sda_drv_q <= 1'b0;
                     bit_cnt_q <= 3'h0;
                     if (state_q == S_AACK && rnw) begin
                        state_q   <= S_RTX;
                        scl_drv_q <= 1'b1;
                        str_cnt_q <= 16'(STRETCH_CYCLES - 1);
                     end else begin
                        state_q <= S_WRX;
                     end
                  end
               end
               S_RTX: begin
                  // Master clocking during the stretch gets the old byte
                  if (scl_rise && scl_drv_q) begin
                     scl_drv_q <= 1'b0;
                     sda_drv_q <= ~tx_q[7];
                  end
                  if (scl_fall && !scl_drv_q) begin
                     bit_cnt_q <= bit_cnt_q + 3'h1;
                     if (last_bit) begin
                        sda_drv_q <= 1'b0;
                        state_q   <= S_RACK;
                     end else begin
                        tx_q      <= {tx_q[6:0], 1'b0};
                        sda_drv_q <= ~tx_q[6];
                     end
                  end
               end
               S_RACK: begin
                  // Pointer moves only on an acknowledged byte; a refusal ends the read
                  if (scl_rise) begin
                     shift_q[0] <= sda_s;
                  end
                  if (scl_fall) begin
                     bit_cnt_q <= 3'h0;
                     if (!shift_q[0]) begin
                        ptr_q     <= ptr_q + 6'h01;
                        state_q   <= S_RTX;
                        scl_drv_q <= 1'b1;
                        str_cnt_q <= 16'(STRETCH_CYCLES - 1);
                     end else begin
                        state_q <= S_SKIP;
                     end
                  end
               end
               default: ;
            endcase
         end
      end
   end

   // Only pull-downs; slave never raises a line itself
   assign link.sda_s_o  = 1'b0;
   assign link.sda_s_oe = sda_drv_q;
   assign link.scl_s_o  = 1'b0;
   assign link.scl_s_oe = scl_drv_q;
   assign reg_ptr_o     = ptr_q;
   assign wr_data_o     = shift_q;
   assign wr_stb_o      = wr_stb_q;
   assign busy_o        = busy_q;
endmodule
`default_nettype wire

// ==== rtl/i2c_master_end.sv ====
// Master end: makes SCL by a divider, starts, stops and bytes
`include "i2c_port_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module i2c_master_end
   import i2c_port_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_sys_i,
   input  wire logic       sys_rst_i,
   // Link
   i2c_link_if.master      link,
   // Command: one byte; start or not before it, stop or not after it
   input  wire logic       cmd_valid_i,
   input  wire logic       cmd_start_i,
   input  wire logic       cmd_stop_i,
   input  wire logic       cmd_read_i,
   input  wire logic       cmd_nak_i,
   input  wire logic [7:0] cmd_data_i,
   output logic            cmd_ready_o,
   // Answer
   output logic            done_o,
   output logic [7:0]      rd_data_o,
   output logic            ack_seen_o
);
   master_state_t state_q;
   logic [1:0] scl_sync_q, sda_sync_q;
   logic [7:0] tick_q;
   logic       phase_q;
   logic [2:0] bit_q;
   logic [7:0] sh_q;
   logic       rd_q, nak_q, stop_q, start_q;
   logic       scl_q, sda_q;
   logic [15:0] free_q;
   logic       done_q, ack_q, ready_q;
   logic [7:0] rd_data_q;

   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         scl_sync_q <= 2'h3;
         sda_sync_q <= 2'h3;
      end else begin
         scl_sync_q <= {scl_sync_q[0], link.scl};
         sda_sync_q <= {sda_sync_q[0], link.sda};
      end
   end

   // Tick every SCL_HALF_CYCLES clocks, a third of a bit; waits while the slave stretches SCL
   wire stretched = scl_q & ~scl_sync_q[1];
   wire tick      = (tick_q == 8'(`SCL_HALF_CYCLES - 1)) & ~stretched;

   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_q <= M_IDLE;
         tick_q  <= 8'h00;
         phase_q <= 1'b0;
         bit_q   <= 3'h0;
         sh_q    <= 8'h00;
         rd_q    <= 1'b0;
         nak_q   <= 1'b0;
         stop_q  <= 1'b0;
         start_q <= 1'b0;
         scl_q   <= 1'b1;
         sda_q   <= 1'b1;
         free_q  <= 16'h0000;
         done_q  <= 1'b0;
         ack_q   <= 1'b0;
         ready_q <= 1'b1;
         rd_data_q <= 8'h00;
      end else begin
         done_q <= 1'b0;
         tick_q <= (tick || stretched || state_q == M_IDLE) ? 8'h00 : tick_q + 8'h01;
         case (state_q)
            M_IDLE: if (cmd_valid_i && ready_q) begin
               ready_q <= 1'b0;
               sh_q    <= cmd_data_i;
               rd_q    <= cmd_read_i;
               nak_q   <= cmd_nak_i;
               stop_q  <= cmd_stop_i;
               start_q <= cmd_start_i;
               bit_q   <= 3'h0;
               phase_q <= 1'b0;
               state_q <= cmd_start_i ? (scl_q ? M_START : M_RSTRT) : M_BIT;
            end
            M_RSTRT: if (tick) begin
               // Raise SDA then SCL before a repeated start
               if (!phase_q) begin
                  sda_q <= 1'b1;
               end else begin
                  scl_q   <= 1'b1;
                  state_q <= M_START;
               end
               phase_q <= ~phase_q;
            end
            M_START: if (tick) begin
               if (!phase_q) begin
                  sda_q <= 1'b0;
               end else begin
                  scl_q   <= 1'b0;
                  state_q <= M_BIT;
               end
               phase_q <= ~phase_q;
            end
            M_BIT: if (tick) begin
               // Phase 0: SCL low, set SDA; phase 1: raise SCL, then sample and lower
               if (phase_q && scl_q) begin
                  sh_q    <= {sh_q[6:0], scl_sync_q[1] ? sda_sync_q[1] : 1'b0};
                  scl_q   <= 1'b0;
                  phase_q <= 1'b0;
                  bit_q   <= bit_q + 3'h1;
                  if (bit_q == 3'h7) begin
                     // Let go of SDA as SCL falls, so the receiver can acknowledge
                     sda_q   <= 1'b1;
                     state_q <= M_ACK;
                  end
               end else if (phase_q) begin
                  scl_q <= 1'b1;
               end else begin
                  sda_q   <= rd_q ? 1'b1 : sh_q[7];
                  scl_q   <= 1'b0;
                  phase_q <= 1'b1;
               end
            end
            M_ACK: if (tick) begin
               if (!phase_q) begin
                  sda_q   <= rd_q ? nak_q : 1'b1;
                  scl_q   <= 1'b0;
                  phase_q <= 1'b1;
               end else if (!scl_q) begin
                  scl_q <= 1'b1;
               end else begin
                  ack_q     <= rd_q ? ~nak_q : ~sda_sync_q[1];
                  // Own acknowledge released as SCL falls; the slave may drive next
                  sda_q     <= 1'b1;
                  rd_data_q <= sh_q;
                  scl_q     <= 1'b0;
                  phase_q   <= 1'b0;
                  state_q   <= stop_q ? M_STOP : M_IDLE;
                  if (!stop_q) begin
                     done_q  <= 1'b1;
                     ready_q <= 1'b1;
                  end
               end
            end
            M_STOP: if (tick) begin
               if (!phase_q) begin
                  sda_q <= 1'b0;
               end else if (!scl_q) begin
                  scl_q <= 1'b1;
               end else begin
                  sda_q   <= 1'b1;
                  free_q  <= 16'(`BUS_FREE_CYCLES);
                  state_q <= M_FREE;
               end
               phase_q <= 1'b1;
            end
            M_FREE: begin
               // Bus free interval before the next start
               if (free_q == 16'h0000) begin
                  state_q <= M_IDLE;
                  done_q  <= 1'b1;
                  ready_q <= 1'b1;
                  phase_q <= 1'b0;
               end else begin
                  free_q <= free_q - 16'h0001;
               end
            end
            default: state_q <= M_IDLE;
         endcase
      end
   end

   assign link.scl_m_o  = 1'b0;
   assign link.scl_m_oe = ~scl_q;
   assign link.sda_m_o  = 1'b0;
   assign link.sda_m_oe = ~sda_q;
   assign cmd_ready_o   = ready_q;
   assign done_o        = done_q;
   assign rd_data_o     = rd_data_q;
   assign ack_seen_o    = ack_q;
endmodule
`default_nettype wire

// ==== testbench/i2c_link_assertions.sv ====
// Concurrent checks on the two-wire link between the master and slave ends
`timescale 1ns/1ps
`default_nettype none
module i2c_link_assertions #(
   parameter int STRETCH_CYCLES = 20
) (
   // Clock and reset
   input  wire logic clk_sys_i,
   input  wire logic sys_rst_i,
   // Link enables and resolved wires
   input  wire logic scl_s_oe,
   input  wire logic sda_s_oe,
   input  wire logic sda_m_oe,
   input  wire logic scl,
   input  wire logic sda
);
   // ----------------------------------------
   // Helper counters
   // ----------------------------------------
   logic [9:0]  idle_cnt_q;
   logic [9:0]  idle_cnt_d;
   logic [15:0] stretch_cnt_q;
   logic [15:0] stretch_cnt_d;

   // Saturates so that a long idle never wraps back to a short one
   assign idle_cnt_d = (scl && sda) ?
      ((idle_cnt_q == 10'h3FF) ? idle_cnt_q : idle_cnt_q + 10'h001) : 10'h000;
   assign stretch_cnt_d = scl_s_oe ? stretch_cnt_q + 16'h0001 : 16'h0000;

   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         idle_cnt_q    <= 10'h3FF;
         stretch_cnt_q <= 16'h0000;
      end else begin
         idle_cnt_q    <= idle_cnt_d;
         stretch_cnt_q <= stretch_cnt_d;
      end
   end

   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (sys_rst_i);

   // ----------------------------------------
   // Properties
   // ----------------------------------------
   property p_start_hold;
      ($fell(sda) && scl) |-> scl[*8];
   endproperty
   a_start_hold: assert property (p_start_hold)
      else $error("clock did not stay high after start");

   property p_bus_free;
      ($fell(sda) && scl) |-> (idle_cnt_q >= 10'h18F);
   endproperty
   a_bus_free: assert property (p_bus_free)
      else $error("start came before the bus free interval");

   property p_slave_no_start;
      ($fell(sda) && scl) |-> !sda_s_oe;
   endproperty
   a_slave_no_start: assert property (p_slave_no_start)
      else $error("slave made a start on the data line");

   property p_stop_release;
      ($rose(sda) && scl) |-> (!sda_s_oe && !scl_s_oe)[*8];
   endproperty
   a_stop_release: assert property (p_stop_release)
      else $error("slave drove the link after stop");

   property p_sda_oe_stable;
      (scl && $past(scl)) |-> $stable(sda_s_oe);
   endproperty
   a_sda_oe_stable: assert property (p_sda_oe_stable)
      else $error("slave changed data while clock high");

   property p_no_overlap;
      not ((sda_s_oe && sda_m_oe)[*8]);
   endproperty
   a_no_overlap: assert property (p_no_overlap)
      else $error("both ends drove the data line too long");

   property p_stretch_low;
      $rose(scl_s_oe) |-> !$past(scl);
   endproperty
   a_stretch_low: assert property (p_stretch_low)
      else $error("stretch began while clock was high");

   property p_stretch_len;
      $fell(scl_s_oe) |-> (stretch_cnt_q >= STRETCH_CYCLES - 2) &&
                          (stretch_cnt_q <= STRETCH_CYCLES + 2);
   endproperty
   a_stretch_len: assert property (p_stretch_len)
      else $error("stretch length wrong");
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
// Self-checking bench: master end driving the slave port over the link
`include "i2c_port_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam int STRETCH = 20;
   localparam int LIMIT   = 90000;

   logic       clk_sys_i = 1'h0;
   logic       sys_rst_i = 1'h1;
   logic       cmd_valid = 1'h0;
   logic       cmd_start = 1'h0;
   logic       cmd_stop  = 1'h0;
   logic       cmd_read  = 1'h0;
   logic       cmd_nak   = 1'h0;
   logic [7:0] cmd_data  = 8'h00;
   logic [2:0] addr_sel  = 3'h0;
   logic [7:0] rd_data_s = 8'h00;
   logic       cmd_ready;
   logic       done;
   logic       ack_seen;
   logic [7:0] rd_data_m;
   logic [5:0] reg_ptr;
   logic [7:0] wr_data;
   logic       wr_stb;
   logic       busy;
   logic [7:0] mem [64];
   logic [7:0] exp_mem [64];
   int         exp_ptr;
   int         fails   = 0;
   int         checked = 0;
   int         cycles  = 0;

   always #12.5 clk_sys_i = ~clk_sys_i;

   i2c_link_if i2c_link_if_inst ();

   i2c_slave_port #(.STRETCH_CYCLES(STRETCH)) i2c_slave_port_inst (
      .clk_sys_i (clk_sys_i),
      .sys_rst_i (sys_rst_i),
      .link      (i2c_link_if_inst.slave),
      .addr_sel_i(addr_sel),
      .reg_ptr_o (reg_ptr),
      .wr_data_o (wr_data),
      .wr_stb_o  (wr_stb),
      .rd_data_i (rd_data_s),
      .busy_o    (busy)
   );

   i2c_master_end i2c_master_end_inst (
      .clk_sys_i  (clk_sys_i),
      .sys_rst_i  (sys_rst_i),
      .link       (i2c_link_if_inst.master),
      .cmd_valid_i(cmd_valid),
      .cmd_start_i(cmd_start),
      .cmd_stop_i (cmd_stop),
      .cmd_read_i (cmd_read),
      .cmd_nak_i  (cmd_nak),
      .cmd_data_i (cmd_data),
      .cmd_ready_o(cmd_ready),
      .done_o     (done),
      .rd_data_o  (rd_data_m),
      .ack_seen_o (ack_seen)
   );

   i2c_link_assertions #(.STRETCH_CYCLES(STRETCH)) i2c_link_assertions_inst (
      .clk_sys_i(clk_sys_i),
      .sys_rst_i(sys_rst_i),
      .scl_s_oe (i2c_link_if_inst.scl_s_oe),
      .sda_s_oe (i2c_link_if_inst.sda_s_oe),
      .sda_m_oe (i2c_link_if_inst.sda_m_oe),
      .scl      (i2c_link_if_inst.scl),
      .sda      (i2c_link_if_inst.sda)
   );

   // ----------------------------------------
   // Register file behind the slave, and timeout
   // ----------------------------------------
   always @(posedge clk_sys_i) begin
      if (wr_stb === 1'h1) begin
         mem[reg_ptr] <= wr_data;
      end
      rd_data_s <= mem[reg_ptr];
      cycles++;
      if (cycles == LIMIT) begin
         fails++;
         finish_test();
      end
   end

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One byte on the link; waits for the answer of the master end
   task automatic xfer(input logic s, input logic p, input logic r, input logic n,
                       input logic [7:0] d);
      int k;
      @(posedge clk_sys_i);
      cmd_valid <= 1'h1;
      cmd_start <= s;
      cmd_stop  <= p;
      cmd_read  <= r;
      cmd_nak   <= n;
      cmd_data  <= d;
      @(posedge clk_sys_i);
      while (cmd_ready !== 1'h1) @(posedge clk_sys_i);
      cmd_valid <= 1'h0;
      k = 0;
      while (done !== 1'h1 && k < 5000) begin
         @(posedge clk_sys_i);
         k++;
      end
      if (k == 5000) begin
         $display("[ERR] done expected 1 seen 0");
         fails++;
         finish_test();
      end
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      int p;
      int v;
      int sel;
      void'($urandom(6295));
      for (int i = 0; i < 64; i++) begin
         mem[i] = $urandom_range(255, 0);
         exp_mem[i] = mem[i];
      end
      repeat (3) @(posedge clk_sys_i);
      sys_rst_i <= 1'h0;
      // Every select level answers to its own address; one random level then refuses two foreign ones
      for (int s = 0; s < 8; s++) begin
         addr_sel <= s[2:0];
         xfer(1'h1, 1'h1, 1'h0, 1'h0, {`ADDR_UPPER, s[2:0], 1'h0});
         check("address ack", 8'h01, {7'h00, ack_seen});
      end
      sel = $urandom_range(7, 0);
      addr_sel <= sel[2:0];
      xfer(1'h1, 1'h1, 1'h0, 1'h0, {`ADDR_UPPER, sel[2:0] ^ 3'h5, 1'h0});
      check("foreign select ack", 8'h00, {7'h00, ack_seen});
      xfer(1'h1, 1'h1, 1'h0, 1'h0, {`ADDR_UPPER ^ 4'h1, sel[2:0], 1'h0});
      check("foreign upper ack", 8'h00, {7'h00, ack_seen});
      // Pointer byte with the unused top bits set, then one data byte
      p = $urandom_range(61, 0);
      v = $urandom_range(255, 0);
      xfer(1'h1, 1'h0, 1'h0, 1'h0, {`ADDR_UPPER, sel[2:0], 1'h0});
      xfer(1'h0, 1'h0, 1'h0, 1'h0, 8'hC0 | p[7:0]);
      check("data ack", 8'h01, {7'h00, ack_seen});
      check("busy mid transfer", 8'h01, {7'h00, busy});
      check("pointer", p[7:0], {2'h0, reg_ptr});
      xfer(1'h0, 1'h1, 1'h0, 1'h0, v[7:0]);
      exp_mem[p] = v[7:0];
      repeat (4) @(posedge clk_sys_i);
      check("written register", exp_mem[p], mem[p]);
      check("busy after stop", 8'h00, {7'h00, busy});
      // Point again, then a sequential read of three bytes
      xfer(1'h1, 1'h0, 1'h0, 1'h0, {`ADDR_UPPER, sel[2:0], 1'h0});
      xfer(1'h0, 1'h1, 1'h0, 1'h0, p[7:0]);
      exp_ptr = p;
      xfer(1'h1, 1'h0, 1'h0, 1'h0, {`ADDR_UPPER, sel[2:0], 1'h1});
      for (int i = 0; i < 3; i++) begin
         xfer(1'h0, i == 2, 1'h1, i == 2, 8'h00);
         check("read byte", exp_mem[exp_ptr], rd_data_m);
         if (i < 2) begin
            exp_ptr = (exp_ptr + 1) % 64;
         end
      end
      check("pointer after read", exp_ptr[7:0], {2'h0, reg_ptr});
      // Read again without a new pointer
      xfer(1'h1, 1'h0, 1'h0, 1'h0, {`ADDR_UPPER, sel[2:0], 1'h1});
      xfer(1'h0, 1'h1, 1'h1, 1'h1, 8'h00);
      check("repeated read", exp_mem[exp_ptr], rd_data_m);
      finish_test();
   end
endmodule
`default_nettype wire
